// ---- bmad_defines.vh ----
// Register offsets, field positions, reset values and decode constants for the address decoder
`ifndef BMAD_DEFINES_VH
`define BMAD_DEFINES_VH

// Register offsets
`define BMAD_OFS_CS_CTRL 8'h44
`define BMAD_OFS_CS_HOLE_BOT 8'h45
`define BMAD_OFS_CS_HOLE_TOP 8'h46
`define BMAD_OFS_CS_TOM 8'h47
`define BMAD_OFS_ISA_FWD_CTRL 8'h48
`define BMAD_OFS_ISA_ROM_FWD 8'h49
`define BMAD_OFS_ISA_HOLE_BOT 8'h4a
`define BMAD_OFS_ISA_HOLE_TOP 8'h4b

// Reset values
`define BMAD_RST_CS_CTRL 8'h00
`define BMAD_RST_CS_HOLE_BOT 8'h10
`define BMAD_RST_CS_HOLE_TOP 8'h0f
`define BMAD_RST_CS_TOM 8'h00
`define BMAD_RST_ISA_FWD_CTRL 8'h01
`define BMAD_RST_ISA_ROM_FWD 8'h00
`define BMAD_RST_ISA_HOLE_BOT 8'h10
`define BMAD_RST_ISA_HOLE_TOP 8'h0f

// Chip-select control fields
`define BMAD_CS_CTRL_MASK 8'h1f
`define BMAD_CS_MASTER_EN 4
`define BMAD_CS_BIOS_WE 3
`define BMAD_CS_BIOS_RE 2
`define BMAD_CS_SEG640_WE 1
`define BMAD_CS_SEG640_RE 0

// ISA forward control fields
`define BMAD_FWD_TOP_HI 7
`define BMAD_FWD_TOP_LO 4
`define BMAD_FWD_LOW512 0
`define BMAD_FWD_SEG640 1
`define BMAD_FWD_VGA 2
`define BMAD_FWD_LOW_BIOS 3

// Address segment codes
`define BMAD_SEG512_TAG 13'h0000
`define BMAD_SEG640_TAG 15'h0004
`define BMAD_VGA_TAG 15'h0005
`define BMAD_ROM_TAG 14'h0003
`define BMAD_LOW_BIOS_TAG 16'h000e
`define BMAD_UP_BIOS_TAG 16'h000f

`endif

// ---- bmad_hole_cmp.v ----
// Hole window comparator on address bits 23 to 16 below 16 MB
`timescale 1ns/1ps
module bmad_hole_cmp (
  // Address under test
  input wire [31:0] addr,
  // Hole bounds, address bits 23 to 16
  input wire [7:0] hole_bot,
  input wire [7:0] hole_top,
  // Result
  output wire in_hole
);

  wire below_16m;
  wire hole_on;
  wire above_bot;
  wire below_top;

  assign below_16m = (addr[31:24] == 8'h00);
  assign hole_on = (hole_top >= hole_bot);
  assign above_bot = (addr[23:16] >= hole_bot);
  assign below_top = (addr[23:16] <= hole_top);
  assign in_hole = below_16m & hole_on & above_bot & below_top;

endmodule

// ---- bmad_decoder.v ----
// Memory address decoder: main memory chip select and ISA to PCI forwarding
//
// Overview of operation
// - Master enable on selects in programmed regions
// - Master enable off never selects
// - Master enable masks external positive decode enables
// - Lowest 512 KB selected whenever master enabled, unless inside the hole
// - Upper BIOS writes selected per enable
// - Upper BIOS reads selected per enable
// - 512-640 KB writes selected per enable
// - 512-640 KB reads selected per enable
// - Both enables off blocks the segment
// - Inclusive hole between bounds suppresses select
// - Hole top below bottom disables hole
// - Hole only applies below 16 MB
// - Hole bounds reset to disabled values
// - 2 MB to top of memory selected
// - Top of memory in 2 MB steps
// - ISA top field gives n plus one MB
// - ISA cycles from 1 MB to top forwarded
// - Low block bits forward ISA cycles
// - BIOS chip select keeps low BIOS on ISA
// - ROM block bits forward 16 KB blocks
// - ISA hole blocks forwarding
`timescale 1ns/1ps
`include "bmad_defines.vh"
module bmad_decoder (
  // Clock, reset, clock enable
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // PCI address phase
  input wire pci_addr_valid,
  input wire [31:0] pci_addr,
  input wire pci_is_mem,
  input wire pci_is_write,
  input wire attr_region_hit,
  // Main memory chip select result
  output reg main_mem_chip_select_n,
  output reg pci_decode_done,
  // ISA master or DMA address
  input wire isa_addr_valid,
  input wire [31:0] isa_addr,
  // Forwarding result
  output reg isa_to_pci,
  output reg isa_decode_done,
  // Positive decode enables from other registers
  input wire isa_clk_div_pos_en,
  input wire bios_chip_select_en,
  // Positive decode enables after masking
  output reg isa_clk_div_pos_en_eff,
  output reg bios_pos_en_eff
);

  // Reset synchroniser
  reg rst_meta_r;
  reg rst_sync_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Configuration registers
  reg [7:0] chipsel_control_r;
  reg [7:0] chipsel_hole_bottom_r;
  reg [7:0] chipsel_hole_top_r;
  reg [7:0] chipsel_top_of_memory_r;
  reg [7:0] isa_forward_control_r;
  reg [7:0] isa_rom_block_forward_r;
  reg [7:0] isa_hole_bottom_r;
  reg [7:0] isa_hole_top_r;

  always @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      chipsel_control_r <= `BMAD_RST_CS_CTRL;
      chipsel_hole_bottom_r <= `BMAD_RST_CS_HOLE_BOT;
      chipsel_hole_top_r <= `BMAD_RST_CS_HOLE_TOP;
      chipsel_top_of_memory_r <= `BMAD_RST_CS_TOM;
      isa_forward_control_r <= `BMAD_RST_ISA_FWD_CTRL;
      isa_rom_block_forward_r <= `BMAD_RST_ISA_ROM_FWD;
      isa_hole_bottom_r <= `BMAD_RST_ISA_HOLE_BOT;
      isa_hole_top_r <= `BMAD_RST_ISA_HOLE_TOP;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `BMAD_OFS_CS_CTRL: begin
          chipsel_control_r <= reg_wdata & `BMAD_CS_CTRL_MASK;
        end
        `BMAD_OFS_CS_HOLE_BOT: begin
          chipsel_hole_bottom_r <= reg_wdata;
        end
        `BMAD_OFS_CS_HOLE_TOP: begin
          chipsel_hole_top_r <= reg_wdata;
        end
        `BMAD_OFS_CS_TOM: begin
          chipsel_top_of_memory_r <= reg_wdata;
        end
        `BMAD_OFS_ISA_FWD_CTRL: begin
          isa_forward_control_r <= reg_wdata;
        end
        `BMAD_OFS_ISA_ROM_FWD: begin
          isa_rom_block_forward_r <= reg_wdata;
        end
        `BMAD_OFS_ISA_HOLE_BOT: begin
          isa_hole_bottom_r <= reg_wdata;
        end
        `BMAD_OFS_ISA_HOLE_TOP: begin
          isa_hole_top_r <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data mux
  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `BMAD_OFS_CS_CTRL: begin
        rdata_nxt = chipsel_control_r & `BMAD_CS_CTRL_MASK;
      end
      `BMAD_OFS_CS_HOLE_BOT: begin
        rdata_nxt = chipsel_hole_bottom_r;
      end
      `BMAD_OFS_CS_HOLE_TOP: begin
        rdata_nxt = chipsel_hole_top_r;
      end
      `BMAD_OFS_CS_TOM: begin
        rdata_nxt = chipsel_top_of_memory_r;
      end
      `BMAD_OFS_ISA_FWD_CTRL: begin
        rdata_nxt = isa_forward_control_r;
      end
      `BMAD_OFS_ISA_ROM_FWD: begin
        rdata_nxt = isa_rom_block_forward_r;
      end
      `BMAD_OFS_ISA_HOLE_BOT: begin
        rdata_nxt = isa_hole_bottom_r;
      end
      `BMAD_OFS_ISA_HOLE_TOP: begin
        rdata_nxt = isa_hole_top_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Chip-select control fields
  wire cs_master_en;
  wire cs_bios_we;
  wire cs_bios_re;
  wire cs_seg640_we;
  wire cs_seg640_re;

  assign cs_master_en = chipsel_control_r[`BMAD_CS_MASTER_EN];
  assign cs_bios_we = chipsel_control_r[`BMAD_CS_BIOS_WE];
  assign cs_bios_re = chipsel_control_r[`BMAD_CS_BIOS_RE];
  assign cs_seg640_we = chipsel_control_r[`BMAD_CS_SEG640_WE];
  assign cs_seg640_re = chipsel_control_r[`BMAD_CS_SEG640_RE];

  // PCI segment decode
  wire pci_in_512k;
  wire pci_in_640k;
  wire pci_in_bios;
  wire pci_in_tom;
  wire pci_in_hole;
  wire pci_seg640_ok;
  wire pci_bios_ok;
  wire pci_region_hit;
  wire cs_nxt;

  assign pci_in_512k = (pci_addr[31:19] == `BMAD_SEG512_TAG);
  assign pci_in_640k = (pci_addr[31:17] == `BMAD_SEG640_TAG);
  assign pci_in_bios = (pci_addr[31:16] == `BMAD_UP_BIOS_TAG);
  // Top of memory region in 2 MB steps
  wire pci_below_512m;
  wire pci_from_2m;
  wire pci_upto_tom;

  assign pci_below_512m = (pci_addr[31:29] == 3'h0);
  assign pci_from_2m = (pci_addr[28:21] != 8'h00);
  assign pci_upto_tom = (pci_addr[28:21] <= chipsel_top_of_memory_r);
  assign pci_in_tom = pci_below_512m & pci_from_2m & pci_upto_tom;

  bmad_hole_cmp u_cs_hole (
    .addr(pci_addr),
    .hole_bot(chipsel_hole_bottom_r),
    .hole_top(chipsel_hole_top_r),
    .in_hole(pci_in_hole)
  );

  // Per-direction segment enables
  wire pci_bios_wr_ok;
  wire pci_bios_rd_ok;
  wire pci_seg640_wr_ok;
  wire pci_seg640_rd_ok;

  assign pci_bios_wr_ok = pci_in_bios & pci_is_write & cs_bios_we;
  assign pci_bios_rd_ok = pci_in_bios & ~pci_is_write & cs_bios_re;
  assign pci_seg640_wr_ok = pci_in_640k & pci_is_write & cs_seg640_we;
  assign pci_seg640_rd_ok = pci_in_640k & ~pci_is_write & cs_seg640_re;
  assign pci_bios_ok = pci_bios_wr_ok | pci_bios_rd_ok;
  assign pci_seg640_ok = pci_seg640_wr_ok | pci_seg640_rd_ok;

  assign pci_region_hit = pci_in_512k | pci_seg640_ok | pci_bios_ok |
                          pci_in_tom | attr_region_hit;

  assign cs_nxt = cs_master_en & pci_is_mem & pci_region_hit & ~pci_in_hole;

  // Chip select registered at address phase, held until the next one
  always @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      main_mem_chip_select_n <= 1'b1;
      pci_decode_done <= 1'b0;
    end else if (clk_en) begin
      pci_decode_done <= pci_addr_valid;
      if (pci_addr_valid) begin
        main_mem_chip_select_n <= ~cs_nxt;
      end
    end
  end

  // ISA segment decode
  wire [3:0] isa_top_field;
  wire isa_in_top;
  wire isa_in_hole;
  wire isa_low_hit;
  wire isa_rom_sel;
  wire isa_rom_hit;
  wire isa_low_bios_ok;
  wire fwd_nxt;

  assign isa_top_field = isa_forward_control_r[`BMAD_FWD_TOP_HI:`BMAD_FWD_TOP_LO];

  assign isa_in_top = (isa_addr[31:24] == 8'h00) &&
                      (isa_addr[23:20] != 4'h0) &&
                      (isa_addr[23:20] <= isa_top_field);

  bmad_hole_cmp u_isa_hole (
    .addr(isa_addr),
    .hole_bot(isa_hole_bottom_r),
    .hole_top(isa_hole_top_r),
    .in_hole(isa_in_hole)
  );

  assign isa_low_bios_ok = isa_forward_control_r[`BMAD_FWD_LOW_BIOS] & ~bios_chip_select_en;

  // Low memory blocks
  wire isa_in_512k;
  wire isa_in_640k;
  wire isa_in_vga;
  wire isa_in_low_bios;

  assign isa_in_512k = (isa_addr[31:19] == `BMAD_SEG512_TAG);
  assign isa_in_640k = (isa_addr[31:17] == `BMAD_SEG640_TAG);
  assign isa_in_vga = (isa_addr[31:17] == `BMAD_VGA_TAG);
  assign isa_in_low_bios = (isa_addr[31:16] == `BMAD_LOW_BIOS_TAG);

  assign isa_low_hit = (isa_in_512k & isa_forward_control_r[`BMAD_FWD_LOW512]) |
                       (isa_in_640k & isa_forward_control_r[`BMAD_FWD_SEG640]) |
                       (isa_in_vga & isa_forward_control_r[`BMAD_FWD_VGA]) |
                       (isa_in_low_bios & isa_low_bios_ok);

  assign isa_rom_sel = (isa_addr[31:18] == `BMAD_ROM_TAG) & ~isa_addr[17];

  // One 16 KB block per enable bit
  wire [7:0] isa_rom_blk_hit;
  genvar blk;

  generate
    for (blk = 0; blk < 8; blk = blk + 1) begin : g_rom_blk
      assign isa_rom_blk_hit[blk] = isa_rom_sel & ({29'h0, isa_addr[16:14]} == blk) &
                                    isa_rom_block_forward_r[blk];
    end
  endgenerate

  assign isa_rom_hit = |isa_rom_blk_hit;

  assign fwd_nxt = (isa_in_top | isa_low_hit | isa_rom_hit) & ~isa_in_hole;

  // Forward decision registered per ISA address, held until the next one
  always @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      isa_to_pci <= 1'b0;
      isa_decode_done <= 1'b0;
    end else if (clk_en) begin
      isa_decode_done <= isa_addr_valid;
      if (isa_addr_valid) begin
        isa_to_pci <= fwd_nxt;
      end
    end
  end

  // Positive decode enables dropped while master enable is set
  always @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      isa_clk_div_pos_en_eff <= 1'b0;
      bios_pos_en_eff <= 1'b0;
    end else if (clk_en) begin
      isa_clk_div_pos_en_eff <= isa_clk_div_pos_en & ~cs_master_en;
      bios_pos_en_eff <= bios_chip_select_en & ~cs_master_en;
    end
  end

endmodule

// ---- bmad_decoder_properties.sv ----
// Concurrent checks on the memory address decoder ports
`timescale 1ns/1ps
module bmad_decoder_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Decode ports
  input wire pci_addr_valid,
  input wire [31:0] pci_addr,
  input wire pci_is_mem,
  input wire main_mem_chip_select_n,
  input wire pci_decode_done,
  input wire isa_addr_valid,
  input wire isa_decode_done,
  input wire isa_clk_div_pos_en,
  input wire bios_chip_select_en,
  input wire isa_clk_div_pos_en_eff,
  input wire bios_pos_en_eff
);
  reg me_r;
  reg [1:0] up_r;
  wire pv = pci_addr_valid && clk_en && up_r[1];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadow of the master enable, live once the internal reset has lifted
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      me_r <= 1'b0;
      up_r <= 2'h0;
    end else begin
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
      if (clk_en && reg_wr && reg_addr == 8'h44 && up_r[1]) me_r <= reg_wdata[4];
    end
  end
  property p_pdone; pv |=> pci_decode_done; endproperty
  a_pdone: assert property (p_pdone) else $error("decode done missing");
  property p_nomem; pv && !pci_is_mem |=> main_mem_chip_select_n; endproperty
  a_nomem: assert property (p_nomem) else $error("select on non-memory");
  property p_off; pv && !me_r |=> main_mem_chip_select_n; endproperty
  a_off: assert property (p_off) else $error("select while disabled");
  property p_low; pv && pci_is_mem && me_r && pci_addr < 32'h80000 |=> !main_mem_chip_select_n; endproperty
  a_low: assert property (p_low) else $error("low segment not selected");
  property p_hold; up_r[1] && !(pci_addr_valid && clk_en) |=> $stable(main_mem_chip_select_n); endproperty
  a_hold: assert property (p_hold) else $error("select moved");
  property p_cdiv; up_r[1] && clk_en |=> isa_clk_div_pos_en_eff == ($past(isa_clk_div_pos_en) && !$past(me_r)); endproperty
  a_cdiv: assert property (p_cdiv) else $error("divisor decode mask");
  property p_bios; up_r[1] && clk_en |=> bios_pos_en_eff == ($past(bios_chip_select_en) && !$past(me_r)); endproperty
  a_bios: assert property (p_bios) else $error("bios decode mask");
  property p_rsv; up_r[1] && clk_en && reg_rd && reg_addr == 8'h44 |=> reg_rdata[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_idone; isa_addr_valid && clk_en && up_r[1] |=> isa_decode_done; endproperty
  a_idone: assert property (p_idone) else $error("isa done missing");
  property p_pdone1; up_r[1] && clk_en && !pci_addr_valid |=> !pci_decode_done; endproperty
  a_pdone1: assert property (p_pdone1) else $error("decode done too long");
  property p_idone1; up_r[1] && clk_en && !isa_addr_valid |=> !isa_decode_done; endproperty
  a_idone1: assert property (p_idone1) else $error("isa done too long");
endmodule
bind bmad_decoder bmad_decoder_checker u_chk (.*);

// ---- bmad_far_model.sv ----
// Far side model: PCI master address phases and ISA master addresses
`timescale 1ns/1ps
module bmad_far_model (
  // Clock
  input wire clk_sys,
  // PCI address phase
  output reg pci_addr_valid,
  output reg [31:0] pci_addr,
  output reg pci_is_mem,
  output reg pci_is_write,
  // ISA master address
  output reg isa_addr_valid,
  output reg [31:0] isa_addr
);
  initial begin
    pci_addr_valid = 1'b0;
    pci_addr = 32'h0;
    pci_is_mem = 1'b0;
    pci_is_write = 1'b0;
    isa_addr_valid = 1'b0;
    isa_addr = 32'h0;
  end
  // One address phase; address and memory-type lines show a changed value afterwards, the write line keeps its value
  task pci(input [31:0] a, input w, input m);
    begin
      @(posedge clk_sys);
      pci_addr_valid <= 1'b1;
      pci_addr <= a;
      pci_is_write <= w;
      pci_is_mem <= m;
      @(posedge clk_sys);
      pci_addr_valid <= 1'b0;
      pci_addr <= ~a;
      pci_is_mem <= ~m;
    end
  endtask
  task isa(input [31:0] a);
    begin
      @(posedge clk_sys);
      isa_addr_valid <= 1'b1;
      isa_addr <= a;
      @(posedge clk_sys);
      isa_addr_valid <= 1'b0;
      isa_addr <= ~a;
    end
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the memory address decoder
`timescale 1ns/1ps
module testbench;
  reg clk_sys, rst_n, reg_wr, reg_rd, attr, cdiv_en, bios_en, ce;
  reg [7:0] reg_addr, reg_wdata;
  reg [71:0] rv = 72'h00100f000100100f00;
  wire [7:0] reg_rdata;
  wire pv, pm, pw, iv, cs_n, isa_to_pci, cdiv_eff, bios_eff;
  wire [31:0] pa, ia;
  integer n_fail = 0, n_checks = 0, cyc = 0, i;
  bmad_decoder dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pci_addr_valid(pv), .pci_addr(pa), .pci_is_mem(pm), .pci_is_write(pw),
    .attr_region_hit(attr), .main_mem_chip_select_n(cs_n), .pci_decode_done(),
    .isa_addr_valid(iv), .isa_addr(ia), .isa_to_pci(isa_to_pci), .isa_decode_done(),
    .isa_clk_div_pos_en(cdiv_en), .bios_chip_select_en(bios_en),
    .isa_clk_div_pos_en_eff(cdiv_eff), .bios_pos_en_eff(bios_eff));
  bmad_far_model far (.clk_sys(clk_sys), .pci_addr_valid(pv), .pci_addr(pa), .pci_is_mem(pm),
    .pci_is_write(pw), .isa_addr_valid(iv), .isa_addr(ia));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  task pc(input [31:0] a, input w, input s);
    begin
      far.pci(a, w, 1'b1);
      #1 chk(cs_n, !s);
    end
  endtask
  task ic(input [31:0] a, input f);
    begin
      far.isa(a);
      #1 chk(isa_to_pci, f);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 8'h0;
    attr = 1'b0;
    cdiv_en = 1'b1;
    bios_en = 1'b1;
    ce = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (i = 0; i < 9; i = i + 1) rd(8'h44 + i[7:0], rv[71 - 8 * i -: 8]);
    pc(32'h0, 0, 0);
    chk(cdiv_eff, 1);
    wr(8'h44, 8'hff);
    rd(8'h44, 8'h1f);
    chk(bios_eff, 0);
    pc(32'h80000, 0, 1);
    pc(32'h9ffff, 1, 1);
    pc(32'hf0000, 0, 1);
    pc(32'hfffff, 1, 1);
    pc(32'h7ffff, 1, 1);
    pc(32'h200000, 0, 0);
    far.pci(32'h0, 0, 0);
    #1 chk(cs_n, 1);
    wr(8'h44, 8'h11);
    pc(32'h80000, 1, 0);
    wr(8'h44, 8'h12);
    pc(32'h80000, 0, 0);
    wr(8'h44, 8'h14);
    pc(32'hf0000, 1, 0);
    wr(8'h44, 8'h18);
    pc(32'hf0000, 0, 0);
    wr(8'h44, 8'h10);
    pc(32'h9ffff, 0, 0);
    pc(32'hffff0, 1, 0);
    pc(32'h0, 0, 1);
    @(posedge clk_sys) attr <= 1'b1;
    pc(32'h100000, 0, 1);
    @(posedge clk_sys) attr <= 1'b0;
    wr(8'h47, 8'h01);
    pc(32'h200000, 0, 1);
    pc(32'h3fffff, 1, 1);
    pc(32'h400000, 0, 0);
    wr(8'h47, 8'hff);
    pc(32'h1fffffff, 0, 1);
    pc(32'h20000000, 0, 0);
    wr(8'h45, 8'h30);
    wr(8'h46, 8'h31);
    pc(32'h2fffff, 0, 1);
    pc(32'h300000, 0, 0);
    pc(32'h31ffff, 1, 0);
    pc(32'h320000, 0, 1);
    pc(32'h1300000, 0, 1);
    wr(8'h45, 8'h32);
    pc(32'h300000, 0, 1);
    @(posedge clk_sys) ce <= 1'b0;
    far.pci(32'h0, 0, 0);
    #1 chk(cs_n, 0);
    @(posedge clk_sys) ce <= 1'b1;
    wr(8'h44, 8'h0f);
    pc(32'hf0000, 0, 0);
    @(posedge clk_sys) bios_en <= 1'b0;
    ic(32'h0, 1);
    ic(32'h80000, 0);
    wr(8'h48, 8'h0e);
    ic(32'h0, 0);
    ic(32'h9ffff, 1);
    ic(32'ha0000, 1);
    ic(32'he0000, 1);
    @(posedge clk_sys) bios_en <= 1'b1;
    ic(32'heffff, 0);
    wr(8'h49, 8'h81);
    ic(32'hc0000, 1);
    ic(32'hc4000, 0);
    ic(32'hdc000, 1);
    wr(8'h48, 8'h30);
    ic(32'h100000, 1);
    ic(32'h3fffff, 1);
    ic(32'h400000, 0);
    wr(8'h4a, 8'h20);
    wr(8'h4b, 8'h21);
    ic(32'h200000, 0);
    ic(32'h21ffff, 0);
    ic(32'h220000, 1);
    wr(8'h48, 8'hf0);
    ic(32'hffffff, 1);
    wr(8'h48, 8'h00);
    ic(32'h100000, 0);
    end_of_test;
  end
endmodule
